// File: inc/ssx_defines.svh
// Constants for the store/subtract/test/xor execution datapath
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH

// ==========================================================
// Widths and sizes
`define SSX_DATA_W 8
`define SSX_RAM_DEPTH 64
`define SSX_RAM_AW 6
`define SSX_REG_AW 4
`define SSX_PC_W 10

// ==========================================================
// Reset values
`define SSX_FLAG_RST 1'b0
`define SSX_PC_RST 10'h000
`define SSX_BYTE_RST 8'h00

`endif

// File: inc/ssx_pkg.sv
// Types shared by the execution datapath
package ssx_pkg;

    // ======================================================
    // Operations carried out by the datapath
    typedef enum logic [2:0] {
        SSX_OP_NONE,
        SSX_OP_STORE,
        SSX_OP_SUB,
        SSX_OP_SUBTRACT_WITH_BORROW,
        SSX_OP_TEST,
        SSX_OP_XOR
    } ssx_op_e;

    // ======================================================
    // One decoded instruction
    typedef struct packed {
        ssx_op_e op;
        logic use_imm;
        logic [3:0] first_sel;
        logic [3:0] second_sel;
        logic [7:0] immediate_constant;
    } ssx_instr_s;

    // ======================================================
    // Write-back to the register file and flags
    typedef struct packed {
        logic reg_we;
        logic [3:0] reg_sel;
        logic [7:0] reg_data;
        logic flags_we;
        logic carry;
        logic zero;
    } ssx_wb_s;

endpackage

// File: rtl/ssx_datapath.sv
// Store, subtract, test and xor execution datapath with scratchpad
// ==========================================================
`include "ssx_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module ssx_datapath #(
    parameter int RAM_DEPTH = `SSX_RAM_DEPTH,
    parameter int NUM_REGS = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Instruction from decode, one cycle per instruction
    input wire logic instr_valid,
    input wire ssx_pkg::ssx_instr_s instr,
    // Register file write-back
    output logic reg_we,
    output logic [3:0] reg_wsel,
    output logic [7:0] reg_wdata,
    // Flags and program counter
    output logic carry_flag,
    output logic zero_flag,
    output logic [`SSX_PC_W-1:0] pc,
    // Scratchpad write port as seen by the core
    output logic ram_we,
    output logic [`SSX_RAM_AW-1:0] ram_waddr,
    output logic [7:0] ram_wdata,
    // Scratchpad read port
    input wire logic [`SSX_RAM_AW-1:0] ram_raddr,
    output logic [7:0] ram_rdata
);

    // ======================================================
    // Elaboration checks
    initial begin
        if (RAM_DEPTH != `SSX_RAM_DEPTH) begin
            $error("Scratchpad depth must be 64");
        end
        if (NUM_REGS != 16) begin
            $error("Register file must have 16 entries");
        end
    end

    // ======================================================
    // Register file
    // Kept here so operands are read in the same cycle as issue
    logic [7:0] regs_ff [NUM_REGS];
    logic [7:0] ram_ff [RAM_DEPTH];
    logic [7:0] first_val;
    logic [7:0] second_val;
    logic [7:0] operand;
    logic [`SSX_RAM_AW-1:0] store_addr;

    assign first_val = regs_ff[instr.first_sel];
    assign second_val = regs_ff[instr.second_sel];
    // Register or immediate chosen once for every operation
    assign operand = instr.use_imm ? instr.immediate_constant
                                   : second_val;
    // Upper two address bits are dropped on purpose
    assign store_addr = operand[`SSX_RAM_AW-1:0];

    // ======================================================
    // Arithmetic and logic
    logic [8:0] diff;
    logic borrow_in;
    logic [7:0] and_res;
    logic [7:0] xor_res;
    ssx_pkg::ssx_wb_s wb;

    // Plain subtract forces borrow in to zero
    assign borrow_in = (instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW)
                       ? carry_flag : 1'b0;
    // Ninth bit is the borrow of the full difference
    assign diff = {1'b0, first_val} - {1'b0, operand}
                  - {8'h00, borrow_in};
    assign and_res = first_val & operand;
    assign xor_res = first_val ^ operand;

    always_comb begin
        wb = '0;
        wb.reg_sel = instr.first_sel;
        case (instr.op)
            ssx_pkg::SSX_OP_SUB,
            ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW: begin
                wb.reg_we = 1'b1;
                wb.reg_data = diff[7:0];
                wb.flags_we = 1'b1;
                wb.carry = diff[8];
                wb.zero = (diff[7:0] == 8'h00);
            end
            ssx_pkg::SSX_OP_TEST: begin
                wb.flags_we = 1'b1;
                wb.carry = ^and_res;
                wb.zero = (and_res == 8'h00);
            end
            ssx_pkg::SSX_OP_XOR: begin
                wb.reg_we = 1'b1;
                wb.reg_data = xor_res;
                wb.flags_we = 1'b1;
                wb.carry = 1'b0;
                wb.zero = (xor_res == 8'h00);
            end
            default: begin
                // Store and idle touch neither flags nor registers
                wb.reg_we = 1'b0;
            end
        endcase
    end

    // ======================================================
    // Register file update
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= `SSX_BYTE_RST;
            end
        end else if (instr_valid && wb.reg_we) begin
            regs_ff[wb.reg_sel] <= wb.reg_data;
        end
    end

    // ======================================================
    // Flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            carry_flag <= `SSX_FLAG_RST;
            zero_flag <= `SSX_FLAG_RST;
        end else if (instr_valid && wb.flags_we) begin
            carry_flag <= wb.carry;
            zero_flag <= wb.zero;
        end
    end

    // ======================================================
    // Scratchpad
    // No reset on the array so it can map to distributed RAM
    logic is_store;
    assign is_store = instr_valid && (instr.op == ssx_pkg::SSX_OP_STORE);

    always_ff @(posedge mclk) begin
        if (is_store) begin
            ram_ff[store_addr] <= first_val;
        end
    end

    assign ram_rdata = ram_ff[ram_raddr];

    // ======================================================
    // Write-back and store port outputs, registered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_we <= 1'b0;
            reg_wsel <= 4'h0;
            reg_wdata <= `SSX_BYTE_RST;
            ram_we <= 1'b0;
            ram_waddr <= 6'h00;
            ram_wdata <= `SSX_BYTE_RST;
        end else begin
            reg_we <= instr_valid && wb.reg_we;
            reg_wsel <= wb.reg_sel;
            reg_wdata <= wb.reg_data;
            ram_we <= is_store;
            ram_waddr <= store_addr;
            ram_wdata <= first_val;
        end
    end

    // ======================================================
    // Program counter
    logic is_ours;
    assign is_ours = instr_valid && (instr.op != ssx_pkg::SSX_OP_NONE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pc <= `SSX_PC_RST;
        end else if (is_ours) begin
            pc <= pc + 10'h001;
        end
    end

    // ======================================================
    // Checks
    a_pc_step: assert property (@(posedge mclk) disable iff (sys_rst)
        is_ours |=> pc == $past(pc) + 10'h001)
        else $error("Program counter did not step by one");

    a_store_flags: assert property (@(posedge mclk)
        disable iff (sys_rst)
        is_store |=> $stable(carry_flag) && $stable(zero_flag) && !reg_we)
        else $error("Store changed flags or a register");

    a_store_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        is_store |=> ram_we && ram_waddr == $past(operand[5:0])
                     && ram_wdata == $past(first_val))
        else $error("Store address or data wrong");

    a_store_mem: assert property (@(posedge mclk) disable iff (sys_rst)
        is_store |=> ram_ff[ram_waddr] == ram_wdata)
        else $error("Scratchpad did not take stored byte");

    a_sub_carry: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUB
        |=> carry_flag == ($past(first_val) < $past(operand)))
        else $error("Subtract borrow wrong");

    a_sub_value: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUB
        |=> reg_wdata == 8'($past(first_val) - $past(operand))
            && zero_flag == (reg_wdata == 8'h00))
        else $error("Subtract result or zero wrong");

    a_subtract_with_borrow_carry: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW
        |=> carry_flag == ({1'b0, $past(first_val)}
            < ({1'b0, $past(operand)} + {8'h00, $past(carry_flag)})))
        else $error("Borrow-subtract carry wrong");

    a_subtract_with_borrow_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW
        |=> zero_flag == (reg_wdata == 8'h00) && reg_we)
        else $error("Borrow-subtract zero wrong");

    a_test_flags: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_TEST
        |=> carry_flag == ^($past(and_res)) && !reg_we
            && zero_flag == ($past(and_res) == 8'h00))
        else $error("Test flags wrong or register written");

    a_xor_flags: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_XOR
        |=> !carry_flag && zero_flag == (reg_wdata == 8'h00)
            && reg_wdata == $past(xor_res))
        else $error("Xor flags or result wrong");

    // ======================================================
    // Checks on refusal, operand choice and write-back
    // Reference values are rebuilt from operands, not from diff

    a_refuse_hold: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !is_ours
        |=> $stable(pc) && $stable(carry_flag) && $stable(zero_flag)
            && !reg_we && !ram_we)
        else $error("Empty slot changed state");

    a_sub_zero: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUB
        |=> zero_flag == ((8'($past(first_val) - $past(operand))) == 8'h00))
        else $error("Subtract zero flag wrong");

    a_sub_nocarry: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUB && carry_flag
        |=> reg_wdata == 8'($past(first_val) - $past(operand)))
        else $error("Subtract used the prior carry");

    a_subtract_with_borrow_value: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW
        |=> reg_wdata == 8'($past(first_val) - $past(operand)
            - {7'h00, $past(carry_flag)}))
        else $error("Borrow-subtract result wrong");

    a_subtract_with_borrow_clear: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW && !carry_flag
        |=> carry_flag == ($past(first_val) < $past(operand)))
        else $error("Borrow-subtract carry without borrow in wrong");

    a_subtract_with_borrow_zbyte: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW
        |=> zero_flag == ((8'($past(first_val) - $past(operand)
            - {7'h00, $past(carry_flag)})) == 8'h00))
        else $error("Borrow-subtract zero flag wrong");

    a_test_keep: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_TEST
        |=> regs_ff[$past(instr.first_sel)] == $past(first_val))
        else $error("Test modified its register");

    a_test_mask: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_TEST && instr.use_imm
        |=> zero_flag == (($past(first_val)
            & $past(instr.immediate_constant)) == 8'h00))
        else $error("Test immediate mask not applied");

    a_xor_zero: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_XOR
        |=> zero_flag == (($past(first_val) ^ $past(operand)) == 8'h00))
        else $error("Xor zero flag wrong");

    a_xor_write: assert property (@(posedge mclk)
        disable iff (sys_rst)
        instr_valid && instr.op == ssx_pkg::SSX_OP_XOR
        |=> reg_we && reg_wsel == $past(instr.first_sel))
        else $error("Xor did not write its register");

    a_store_source: assert property (@(posedge mclk)
        disable iff (sys_rst)
        is_store
        |=> ram_waddr == ($past(instr.use_imm)
            ? $past(instr.immediate_constant[5:0])
            : $past(second_val[5:0])))
        else $error("Store address source wrong");

    a_store_keep: assert property (@(posedge mclk)
        disable iff (sys_rst)
        is_store
        |=> regs_ff[$past(instr.first_sel)] == $past(first_val))
        else $error("Store modified a register");

    a_reg_file: assert property (@(posedge mclk)
        disable iff (sys_rst)
        reg_we
        |-> regs_ff[reg_wsel] == reg_wdata)
        else $error("Register file disagrees with write-back");

    a_ram_hold: assert property (@(posedge mclk)
        disable iff (sys_rst)
        ram_we
        |-> ram_ff[ram_waddr] == ram_wdata)
        else $error("Scratchpad location lost the stored byte");

    a_idle_pc: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !instr_valid
        |=> $stable(pc) && !reg_we && !ram_we)
        else $error("Idle cycle advanced the program counter");

endmodule

`default_nettype wire

// File: test/test_store_sub_test_xor_datapath.sv
// Self-checking bench for the store/subtract/test/xor datapath
`timescale 1ns/100ps
`default_nettype none

module test_store_sub_test_xor_datapath;
    // ==========================================================
    // Stimulus, outputs and reference state
    localparam ssx_pkg::ssx_op_e k_st = ssx_pkg::SSX_OP_STORE;
    localparam ssx_pkg::ssx_op_e k_sub = ssx_pkg::SSX_OP_SUB;
    localparam ssx_pkg::ssx_op_e k_sbc = ssx_pkg::SSX_OP_SUBTRACT_WITH_BORROW;
    localparam ssx_pkg::ssx_op_e k_tst = ssx_pkg::SSX_OP_TEST;
    localparam ssx_pkg::ssx_op_e k_xor = ssx_pkg::SSX_OP_XOR;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    ssx_pkg::ssx_instr_s instr = '0;
    logic [5:0] ram_raddr = 6'h00;
    logic reg_we, carry_flag, zero_flag, ram_we;
    logic [3:0] reg_wsel;
    logic [7:0] reg_wdata, ram_wdata, ram_rdata;
    logic [9:0] pc;
    logic [5:0] ram_waddr;
    logic [7:0] rf [16];
    logic [7:0] mem [64];
    logic m_c = 1'b0;
    logic m_z = 1'b0;
    logic [9:0] m_pc = 10'h000;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #12.5 mclk = ~mclk;

    ssx_datapath u_dut (
        .mclk(mclk), .sys_rst(sys_rst),
        .instr_valid(instr_valid), .instr(instr),
        .reg_we(reg_we), .reg_wsel(reg_wsel), .reg_wdata(reg_wdata),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .pc(pc),
        .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
        .ram_raddr(ram_raddr), .ram_rdata(ram_rdata)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(string nm, logic [9:0] exp, logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Issues back to back; valid stays up so the next call follows on
    task automatic exec(ssx_pkg::ssx_op_e op, logic use_k,
            logic [3:0] fs, logic [3:0] ss, logic [7:0] k);
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] r;
        logic [8:0] d;
        logic we;
        logic st;
        instr = '{op, use_k, fs, ss, k};
        instr_valid = 1'b1;
        a = rf[fs];
        b = use_k ? k : rf[ss];
        d = {1'b0, a} - {1'b0, b} - 9'(m_c && op == k_sbc);
        we = (op == k_sub) || (op == k_sbc) || (op == k_xor);
        st = (op == k_st);
        r = (op == k_xor) ? (a ^ b) : ((op == k_tst) ? (a & b) : d[7:0]);
        if (!st) begin
            m_c = (op == k_tst) ? ^r : ((op == k_xor) ? 1'b0 : d[8]);
            m_z = (r == 8'h00);
        end
        @(posedge mclk);
        #1;
        m_pc = m_pc + 10'h001;
        chk("reg_we", 10'(we), 10'(reg_we));
        chk("carry", 10'(m_c), 10'(carry_flag));
        chk("zero", 10'(m_z), 10'(zero_flag));
        chk("pc", m_pc, pc);
        chk("ram_we", 10'(st), 10'(ram_we));
        if (we) begin
            rf[fs] = r;
            chk("reg_wsel", 10'(fs), 10'(reg_wsel));
            chk("reg_wdata", 10'(r), 10'(reg_wdata));
        end
        if (st) begin
            mem[b[5:0]] = a;
            chk("ram_waddr", 10'(b[5:0]), 10'(ram_waddr));
            chk("ram_wdata", 10'(a), 10'(ram_wdata));
        end
    endtask

    // Registers are only reachable through instructions
    task automatic load(logic [3:0] r, logic [7:0] v);
        exec(k_xor, 1'b0, r, r, 8'h00);
        exec(k_xor, 1'b1, r, 4'h0, v);
    endtask

    // ==========================================================
    // Scenarios
    task automatic sc_sub();
        load(4'h1, 8'h03);
        exec(k_sub, 1'b1, 4'h1, 4'h0, 8'h05);
        exec(k_sub, 1'b1, 4'h1, 4'h0, 8'h10);
        load(4'h2, 8'hee);
        exec(k_sub, 1'b1, 4'h3, 4'h0, 8'h01);
        exec(k_sub, 1'b0, 4'h1, 4'h2, 8'h00);
    endtask

    task automatic sc_subtract_with_borrow();
        load(4'h4, 8'h00);
        load(4'h5, 8'h01);
        exec(k_sub, 1'b1, 4'h4, 4'h0, 8'h01);
        exec(k_sbc, 1'b1, 4'h5, 4'h0, 8'h00);
        load(4'h6, 8'h00);
        exec(k_sub, 1'b1, 4'h7, 4'h0, 8'h01);
        exec(k_sbc, 1'b1, 4'h6, 4'h0, 8'hff);
        exec(k_sbc, 1'b0, 4'h7, 4'h6, 8'h00);
    endtask

    task automatic sc_test();
        load(4'h8, 8'hb6);
        load(4'h9, 8'h34);
        exec(k_tst, 1'b1, 4'h8, 4'h0, 8'h07);
        exec(k_tst, 1'b1, 4'h8, 4'h0, 8'h49);
        exec(k_tst, 1'b0, 4'h8, 4'h9, 8'h00);
        exec(k_xor, 1'b1, 4'h8, 4'h0, 8'h00);
    endtask

    task automatic sc_xor();
        exec(k_sub, 1'b1, 4'h7, 4'h0, 8'hff);
        exec(k_xor, 1'b0, 4'h7, 4'h7, 8'h00);
        exec(k_xor, 1'b1, 4'h7, 4'h0, 8'h5a);
    endtask

    task automatic sc_store();
        for (int i = 0; i < 64; i++) begin
            exec(k_sub, 1'b1, 4'ha, 4'h0, 8'h03);
            exec(k_st, 1'b1, 4'ha, 4'h0, 8'(i) | 8'hc0);
        end
        load(4'hb, 8'h85);
        exec(k_st, 1'b0, 4'ha, 4'hb, 8'h00);
        instr_valid = 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(posedge mclk);
            #1 ram_raddr = 6'(i);
            #1 chk("ram_rdata", 10'(mem[i]), 10'(ram_rdata));
        end
    endtask

    // Idle and empty slots must leave all state alone
    task automatic sc_refuse();
        @(posedge mclk);
        #1 instr = '{k_sub, 1'b1, 4'h1, 4'h0, 8'h01};
        @(posedge mclk);
        #1 chk("pc", m_pc, pc);
        instr_valid = 1'b1;
        instr.op = ssx_pkg::SSX_OP_NONE;
        @(posedge mclk);
        #1 chk("pc", m_pc, pc);
        exec(k_xor, 1'b1, 4'h1, 4'h0, 8'h00);
    endtask

    // ==========================================================
    // Run control
    task automatic print_verdict();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) rf[i] = 8'h00;
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'b0;
        chk("pc", m_pc, pc);
        sc_sub();
        sc_subtract_with_borrow();
        sc_test();
        sc_xor();
        sc_store();
        sc_refuse();
        print_verdict();
    end
endmodule

`default_nettype wire
